/* core/alu_params.svh */
// alu_params.svh: register offsets, field positions and reset values
// assumes: included by bare name from the top module
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

// ==========================================================
// register byte offsets (12-bit apb address)
`define ACC_OFFSET 12'h000
`define FLAGS_OFFSET 12'h004
`define COMMAND_OFFSET 12'h008
`define RESULT_OFFSET 12'h00C
`define OPCOUNT_OFFSET 12'h010
`define FILE_WINDOW_TAG 3'h1

// ==========================================================
// field positions
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_DEST_BIT 3
`define CMD_ADDR_LSB 8
`define CMD_ADDR_MSB 14
`define CMD_LIT_LSB 16
`define CMD_LIT_MSB 23
`define FLAGS_ZERO_BIT 0
`define FLAGS_CARRY_BIT 1
`define FLAGS_ILLEGAL_BIT 2

// ==========================================================
// reset values
`define ACC_RESET 8'h00
`define FILE_RESET 8'h00
`define RESULT_RESET 8'h00
`define OPCOUNT_RESET 16'h0000
`define READ_RESET 32'h0000_0000

`endif

/* core/alu_pkg.sv */
// alu_pkg: types shared by the alu top, its compute unit and their link
// assumes: constants come from alu_params.svh
package alu_pkg;

    // ==========================================================
    // operation codes, in command-field order
    typedef enum logic [2:0] {
        OR_LITERAL_INTO_ACCUMULATOR,
        INCREMENT_REGISTER_OP,
        OR_ACCUMULATOR_WITH_REGISTER,
        LOGICAL_SHIFT_UP_OP,
        LOGICAL_SHIFT_DOWN_OP,
        COPY_REGISTER_OP
    } alu_op_e;

    // register decode result
    typedef enum logic [2:0] {
        REG_ACC,
        REG_FLAGS,
        REG_COMMAND,
        REG_RESULT,
        REG_OPCOUNT,
        REG_FILE,
        REG_NONE
    } reg_kind_e;

    typedef logic [7:0] byte_t;

    // whole state of the top module
    typedef struct packed {
        logic [127:0][7:0] files;
        byte_t acc;
        logic zeroFlag;
        logic carryFlag;
        logic illegalFlag;
        byte_t lastResult;
        logic [15:0] opCount;
        logic [31:0] readData;
        logic dataReady;
    } alu_state_s;

endpackage

/* core/alu_op_if.sv */
// alu_op_if: operands and results between the alu top and its compute unit
// assumes: both ends sit in the same clock domain; the link itself is combinational
`timescale 1ns/1ps
interface alu_op_if;
    alu_pkg::alu_op_e op;
    alu_pkg::byte_t acc;
    alu_pkg::byte_t operand;
    alu_pkg::byte_t literal;
    logic carryIn;
    alu_pkg::byte_t result;
    logic zeroOut;
    logic carryOut;
    logic carryAffected;

    modport requester (
        output op, acc, operand, literal, carryIn,
        input result, zeroOut, carryOut, carryAffected
    );
    modport compute (
        input op, acc, operand, literal, carryIn,
        output result, zeroOut, carryOut, carryAffected
    );
endinterface

/* core/alu_compute.sv */
// alu_compute: combinational result and flag logic for one operation
// assumes: the requester discards results for illegal op codes and picks the destination
`timescale 1ns/1ps
module alu_compute (
    alu_op_if.compute link
);

    // ==========================================================
    // result and flags
    always_comb begin
        link.result = link.acc;
        link.carryOut = link.carryIn;
        link.carryAffected = 1'b0;
        unique case (link.op)
            alu_pkg::OR_LITERAL_INTO_ACCUMULATOR: begin
                link.result = link.acc | link.literal;
            end
            alu_pkg::INCREMENT_REGISTER_OP: begin
                link.result = link.operand + 8'h01; // wraps
            end
            alu_pkg::OR_ACCUMULATOR_WITH_REGISTER: begin
                link.result = link.acc | link.operand;
            end
            alu_pkg::LOGICAL_SHIFT_UP_OP: begin
                link.result = {link.operand[6:0], 1'b0};
                link.carryOut = link.operand[7];
                link.carryAffected = 1'b1;
            end
            alu_pkg::LOGICAL_SHIFT_DOWN_OP: begin
                link.result = {1'b0, link.operand[7:1]};
                link.carryOut = link.operand[0];
                link.carryAffected = 1'b1;
            end
            alu_pkg::COPY_REGISTER_OP: begin
                link.result = link.operand;
            end
            default: begin
                link.result = link.acc; // illegal code, caller discards
            end
        endcase
        // zero test on the final 8-bit value
        link.zeroOut = (link.result == 8'h00);
    end

endmodule // alu_compute

/* core/or_increment_shift_move_alu.sv */
// or_increment_shift_move_alu: apb-reached alu for or, increment, shifts and move
// assumes: one 10 MHz clock, synchronous active-low reset, apb3 master on the bus
//
// Functional notes
// - The literal or combines the accumulator with an 8-bit literal and writes the accumulator and zero flag.
// - The increment adds one to the addressed file byte and sends the sum to the selected destination, updating zero.
// - A destination bit of zero sends the result to the accumulator, one sends it back to the file byte.
// - The register or combines accumulator and file byte into the selected destination and updates zero.
// - The left shift puts bit 7 in carry, bits 6..0 in result 7..1, zero in bit 0, and updates carry and zero.
// - The right shift puts zero in bit 7, bits 7..1 in result 6..0, bit 0 in carry, and updates carry and zero.
// - The copy moves the file byte to the selected destination and updates zero, so a self-copy tests for zero.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "alu_params.svh"
module or_increment_shift_move_alu (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clockEnable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ==========================================================
    // address decode
    // used for read capture, writes and the error answer
    function automatic alu_pkg::reg_kind_e decodeReg(input logic [11:0] addr);
        alu_pkg::reg_kind_e kind;
        kind = alu_pkg::REG_NONE;
        if (addr[1:0] == 2'h0) begin
            if (addr[11:9] == `FILE_WINDOW_TAG) begin
                kind = alu_pkg::REG_FILE;
            end else if (addr == `ACC_OFFSET) begin
                kind = alu_pkg::REG_ACC;
            end else if (addr == `FLAGS_OFFSET) begin
                kind = alu_pkg::REG_FLAGS;
            end else if (addr == `COMMAND_OFFSET) begin
                kind = alu_pkg::REG_COMMAND;
            end else if (addr == `RESULT_OFFSET) begin
                kind = alu_pkg::REG_RESULT;
            end else if (addr == `OPCOUNT_OFFSET) begin
                kind = alu_pkg::REG_OPCOUNT;
            end
        end
        return kind;
    endfunction

    // legal operation codes only
    function automatic logic isLegalOp(input logic [2:0] code);
        return code <= 3'(alu_pkg::COPY_REGISTER_OP);
    endfunction

    // ==========================================================
    // state
    localparam alu_pkg::alu_state_s RESET_STATE = '{
        files: {128{`FILE_RESET}},
        acc: `ACC_RESET,
        zeroFlag: 1'b0,
        carryFlag: 1'b0,
        illegalFlag: 1'b0,
        lastResult: `RESULT_RESET,
        opCount: `OPCOUNT_RESET,
        readData: `READ_RESET,
        dataReady: 1'b0
    };

    alu_pkg::alu_state_s state;
    alu_pkg::alu_state_s next_state;

    // ==========================================================
    // bus phase and command fields
    logic setupOrWait;
    logic accessPhase;
    logic transferDone;
    alu_pkg::reg_kind_e kind;
    logic [2:0] cmdCode;
    logic cmdDest;
    logic [6:0] cmdAddr;
    logic [6:0] busFileAddr;
    alu_pkg::byte_t cmdLiteral;
    logic cmdLegal;
    logic toAccumulator;

    // phase flags
    assign accessPhase = psel && penable;
    assign setupOrWait = psel && !pwrite && !state.dataReady;
    assign transferDone = accessPhase && pready;
    assign kind = decodeReg(paddr);

    // command word fields
    assign cmdCode = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
    assign cmdDest = pwdata[`CMD_DEST_BIT];
    assign cmdAddr = pwdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
    assign cmdLiteral = pwdata[`CMD_LIT_MSB:`CMD_LIT_LSB];
    assign cmdLegal = isLegalOp(cmdCode);
    assign busFileAddr = paddr[8:2];

    // literal or always lands in the accumulator
    assign toAccumulator = (cmdCode == 3'(alu_pkg::OR_LITERAL_INTO_ACCUMULATOR)) || !cmdDest;

    // ==========================================================
    // compute unit
    alu_op_if aluLink ();

    // operands for the unit
    assign aluLink.op = alu_pkg::alu_op_e'(cmdCode);
    assign aluLink.acc = state.acc;
    assign aluLink.operand = state.files[cmdAddr];
    assign aluLink.literal = cmdLiteral;
    assign aluLink.carryIn = state.carryFlag;

    alu_compute computeUnit (
        .link(aluLink.requester)
    );

    // ==========================================================
    // bus answer
    // reads capture data on the setup-phase edge; reads and writes both finish at once
    assign pready = clockEnable && (pwrite || state.dataReady);
    assign pslverr = accessPhase && (kind == alu_pkg::REG_NONE);
    assign prdata = state.readData;

    // ==========================================================
    // next state
    always_comb begin
        next_state = state;

        // read capture, held until the transfer ends
        if (setupOrWait) begin
            next_state.dataReady = 1'b1;
            unique case (kind)
                alu_pkg::REG_ACC: next_state.readData = {24'h00_0000, state.acc};
                alu_pkg::REG_FLAGS: next_state.readData = {29'h0000_0000, state.illegalFlag,
                    state.carryFlag, state.zeroFlag};
                alu_pkg::REG_COMMAND: next_state.readData = 32'h0000_0000;
                alu_pkg::REG_RESULT: next_state.readData = {24'h00_0000, state.lastResult};
                alu_pkg::REG_OPCOUNT: next_state.readData = {16'h0000, state.opCount};
                alu_pkg::REG_FILE: next_state.readData = {24'h00_0000, state.files[busFileAddr]};
                alu_pkg::REG_NONE: next_state.readData = 32'h0000_0000;
            endcase
        end
        if (transferDone) begin
            next_state.dataReady = 1'b0;
        end

        // register writes
        if (transferDone && pwrite) begin
            unique case (kind)
                alu_pkg::REG_ACC: begin
                    next_state.acc = pwdata[7:0];
                end
                alu_pkg::REG_FLAGS: begin
                    next_state.zeroFlag = pwdata[`FLAGS_ZERO_BIT];
                    next_state.carryFlag = pwdata[`FLAGS_CARRY_BIT];
                    // write one to clear the sticky illegal flag
                    if (pwdata[`FLAGS_ILLEGAL_BIT]) begin
                        next_state.illegalFlag = 1'b0;
                    end
                end
                alu_pkg::REG_FILE: begin
                    next_state.files[busFileAddr] = pwdata[7:0];
                end
                alu_pkg::REG_COMMAND: begin
                    if (!cmdLegal) begin
                        next_state.illegalFlag = 1'b1; // illegal code: only the sticky flag is set
                    end else begin
                        next_state.lastResult = aluLink.result;
                        next_state.opCount = state.opCount + 16'h0001;
                        next_state.zeroFlag = aluLink.zeroOut;
                        // only the shifts touch carry
                        if (aluLink.carryAffected) begin
                            next_state.carryFlag = aluLink.carryOut;
                        end
                        // destination routing
                        if (toAccumulator) begin
                            next_state.acc = aluLink.result;
                        end else begin
                            next_state.files[cmdAddr] = aluLink.result;
                        end
                    end
                end
                alu_pkg::REG_RESULT, alu_pkg::REG_OPCOUNT, alu_pkg::REG_NONE: begin
                    next_state.dataReady = 1'b0; // read-only or unmapped: no effect
                end
            endcase
        end
    end

    // ==========================================================
    // state register, frozen while clock enable is low
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= RESET_STATE;
        end else if (clockEnable) begin
            state <= next_state;
        end
    end

endmodule // or_increment_shift_move_alu

/* sim/alu_checker.sv */
// alu_checker: bus and result-width assertions on the alu top ports
// assumes: bound to or_increment_shift_move_alu, one clock, rst_b sync active low
`timescale 1ns/1ps
module alu_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clockEnable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ==========================================================
    // properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic rdDone;
    // completed read, data sampled here
    assign rdDone = psel && penable && pready && !pwrite;
    property p_acc8; rdDone && paddr == 12'h000 |-> prdata[31:8] == 24'h00_0000; endproperty
    property p_file8; rdDone && paddr[11:9] == 3'h1 |-> prdata[31:8] == 24'h00_0000; endproperty
    property p_res8; rdDone && paddr == 12'h00C |-> prdata[31:8] == 24'h00_0000; endproperty
    property p_flags; rdDone && paddr == 12'h004 |-> prdata[31:3] == 29'h0000_0000; endproperty
    property p_wrfast; psel && penable && pwrite && clockEnable |-> pready; endproperty
    property p_rdfast; psel && !penable && !pwrite && clockEnable ##1 penable && clockEnable |-> pready; endproperty
    property p_unalign; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    property p_cmdok; psel && penable && paddr == 12'h008 |-> !pslverr && (pwrite || prdata == 32'h0000_0000);
    endproperty
    property p_frozen; !clockEnable |-> !pready; endproperty
    a_acc8: assert property (p_acc8) else $error("acc read wider than a byte");
    a_file8: assert property (p_file8) else $error("file read wider than a byte");
    a_res8: assert property (p_res8) else $error("result wider than a byte");
    a_flags: assert property (p_flags) else $error("flags upper bits set");
    a_wrfast: assert property (p_wrfast) else $error("write not answered at once"); // bus timing
    a_rdfast: assert property (p_rdfast) else $error("read not answered at once"); // bus timing
    a_unalign: assert property (p_unalign) else $error("unaligned access without error"); // bus error
    a_cmdok: assert property (p_cmdok) else $error("command access misbehaved"); // bus map
    a_frozen: assert property (p_frozen) else $error("ready while frozen");
    c_wr: cover property (psel && penable && pready && pwrite);
    c_rd: cover property (rdDone);
    c_err: cover property (psel && penable && pslverr);
endmodule // alu_checker
bind or_increment_shift_move_alu alu_checker chk_u (.clock(clock), .rst_b(rst_b), .clockEnable(clockEnable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

/* sim/or_increment_shift_move_alu_tb.sv */
// or_increment_shift_move_alu_tb: self-checking bench over apb
// assumes: design map 0x000 acc, 0x004 flags, 0x008 command, 0x200+4n file bytes
`timescale 1ns/1ps
module or_increment_shift_move_alu_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic clockEnable = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int err_total = 0;
    int cmp_count = 0;

    or_increment_shift_move_alu dut_u (.clock(clock), .rst_b(rst_b), .clockEnable(clockEnable), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // ==========================================================
    // clock, 100 ns period
    initial begin
        forever #50 clock = ~clock;
    end

    // ==========================================================
    // bus and compare tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1 && ++n < 100);
        if (n >= 100) err_total++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        cmp(r, exp);
    endtask
    // one command: op, destination, file index, literal
    task automatic op(input logic [2:0] c, input logic d, input logic [6:0] f, input logic [7:0] k);
        wr(12'h008, {8'h00, k, 1'b0, f, 4'h0, d, c});
    endtask
    function automatic logic [11:0] fa(input logic [6:0] n);
        return {3'h1, n, 2'b00};
    endfunction

    // ==========================================================
    // scenarios
    // fresh after reset: status registers, one legal op, an illegal code, flag write and clear
    task automatic t_misc();
        chk(12'h010, 32'h0000_0000);
        op(3'h0, 1'b0, 7'h00, 8'hF0);
        chk(12'h00C, 32'h0000_00F0);
        chk(12'h010, 32'h0000_0001);
        wr(12'h00C, 32'h0000_0055);
        chk(12'h00C, 32'h0000_00F0);
        op(3'h6, 1'b0, 7'h00, 8'h0F);
        chk(12'h004, 32'h0000_0004);
        chk(12'h000, 32'h0000_00F0);
        chk(12'h010, 32'h0000_0001);
        chk(12'h008, 32'h0000_0000);
        wr(12'h004, 32'h0000_0007);
        chk(12'h004, 32'h0000_0003);
        wr(12'h004, 32'h0000_0000);
    endtask
    task automatic t_literal();
        wr(12'h000, 32'h0000_0030);
        op(3'h0, 1'b1, 7'h00, 8'h05);
        chk(12'h000, 32'h0000_0035);
        chk(12'h004, 32'h0000_0000);
        wr(12'h000, 32'h0000_0000);
        op(3'h0, 1'b0, 7'h00, 8'h00);
        chk(12'h004, 32'h0000_0001);
    endtask
    task automatic t_incr();
        wr(fa(7'h7F), 32'h0000_00FF);
        op(3'h1, 1'b1, 7'h7F, 8'h00);
        chk(fa(7'h7F), 32'h0000_0000);
        chk(12'h004, 32'h0000_0001);
        wr(fa(7'h05), 32'h0000_007F);
        op(3'h1, 1'b0, 7'h05, 8'h00);
        chk(12'h000, 32'h0000_0080);
        chk(fa(7'h05), 32'h0000_007F);
    endtask
    task automatic t_oreg();
        wr(12'h000, 32'h0000_000A);
        wr(fa(7'h03), 32'h0000_0050);
        op(3'h2, 1'b1, 7'h03, 8'h00);
        chk(fa(7'h03), 32'h0000_005A);
        chk(12'h000, 32'h0000_000A);
        chk(12'h004, 32'h0000_0000);
    endtask
    task automatic t_copy();
        wr(fa(7'h09), 32'h0000_0000);
        op(3'h5, 1'b1, 7'h09, 8'h00);
        chk(12'h004, 32'h0000_0001);
        wr(fa(7'h09), 32'h0000_0044);
        op(3'h5, 1'b0, 7'h09, 8'h00);
        chk(12'h000, 32'h0000_0044);
        chk(12'h004, 32'h0000_0000);
    endtask
    task automatic t_shift();
        wr(fa(7'h10), 32'h0000_0081);
        op(3'h3, 1'b0, 7'h10, 8'h00);
        chk(12'h000, 32'h0000_0002);
        chk(12'h004, 32'h0000_0002);
        wr(fa(7'h11), 32'h0000_0001);
        op(3'h4, 1'b1, 7'h11, 8'h00);
        chk(fa(7'h11), 32'h0000_0000);
        chk(12'h004, 32'h0000_0003);
        wr(fa(7'h12), 32'h0000_00FE);
        op(3'h4, 1'b0, 7'h12, 8'h00);
        chk(12'h000, 32'h0000_007F);
        chk(12'h004, 32'h0000_0000);
        op(3'h3, 1'b1, 7'h12, 8'h00);
        chk(fa(7'h12), 32'h0000_00FC);
        chk(12'h004, 32'h0000_0002);
    endtask
    task automatic t_bus();
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'h102, 32'h0000_0000, r, e);
        cmp({31'h0000_0000, e}, 32'h0000_0001);
        cmp(r, 32'h0000_0000);
    endtask
    // clock enable low: the access phase gets no answer and the write waits for it
    task automatic t_freeze();
        wr(12'h000, 32'h0000_0011);
        @(posedge clock);
        clockEnable <= 1'b0;
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= 12'h000;
        pwdata <= 32'h0000_0022;
        @(posedge clock);
        penable <= 1'b1;
        repeat (3) @(posedge clock);
        cmp({31'h0000_0000, pready}, 32'h0000_0000);
        clockEnable <= 1'b1;
        @(posedge clock);
        cmp({31'h0000_0000, pready}, 32'h0000_0001);
        psel <= 1'b0;
        penable <= 1'b0;
        chk(12'h000, 32'h0000_0022);
    endtask

    // ==========================================================
    // verdict and end of run
    task automatic summarize();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence after a two-cycle reset
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        t_misc();
        t_literal();
        t_incr();
        t_oreg();
        t_copy();
        t_shift();
        t_bus();
        t_freeze();
        summarize();
    end

    // watchdog
    initial begin
        #2000000;
        err_total++;
        summarize();
    end
endmodule // or_increment_shift_move_alu_tb
